// ### bench/apc_host.sv
// Purpose: host model loading setup words in select-framed commands
// Assumes: load port stands for the serial command decoder
// Notes: released data bus shows inverted data, never the last value
`timescale 1ns/1ps
`default_nettype none
module apc_host (
    // clock
    input wire logic clk,
    // load port
    output var logic word_load,
    output var logic word_sel_b,
    output var apc_pkg::apc_word_t word_data,
    output var logic ss_n
);
    import apc_pkg::*;
    initial begin
        word_load = 1'b0;
        word_sel_b = 1'b0;
        word_data = 16'h0000;
        ss_n = 1'b1;
    end
    task automatic frame(input logic do_a, input logic do_b,
                         input apc_word_t a, input apc_word_t b);
        @(posedge clk);
        ss_n <= 1'b0;
        if (do_a) begin
            @(posedge clk);
            word_load <= 1'b1;
            word_sel_b <= 1'b0;
            word_data <= a;
        end
        if (do_b) begin
            @(posedge clk);
            word_load <= 1'b1;
            word_sel_b <= 1'b1;
            word_data <= b;
        end
        @(posedge clk);
        word_load <= 1'b0;
        word_data <= ~word_data;
        ss_n <= 1'b1;
        repeat (4) @(posedge clk);
    endtask
endmodule
`default_nettype wire

// ### bench/apc_monitor.sv
// Purpose: port checker for the audio path setup bank
// Assumes: one clock domain, asynchronous active-low reset
// Notes: decode is checked one cycle after the active words it follows
`timescale 1ns/1ps
`default_nettype none
module apc_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // load side
    input wire logic word_load,
    input wire logic word_sel_b,
    input wire apc_pkg::apc_word_t word_data,
    input wire logic ss_n,
    input wire logic power_up_bit,
    // decoded controls and status
    input wire apc_pkg::apc_mix_t first_summer_mix,
    input wire apc_pkg::apc_mix_t second_summer_mix,
    input wire apc_pkg::apc_rate_t rate_sel,
    input wire apc_pkg::apc_vsrc_t volume_source_sel,
    input wire logic filter_power_down,
    input wire logic mic_gain_power_down,
    input wire logic volume_power_down,
    input wire logic [4:0] atten_db,
    input wire logic spk_high_gain,
    input wire logic aux_out_power_down,
    input wire apc_pkg::apc_word_t path_setup_word_a,
    input wire apc_pkg::apc_word_t path_setup_word_b,
    input wire logic commit_pending
);
    import apc_pkg::*;
    apc_word_t held_b_r, wa_r, wb_r;
    logic pu_r;
    // delayed copies, since decode lags the words by one cycle
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            held_b_r <= 16'h01e3;
            wa_r <= 16'h2421;
            wb_r <= 16'h01e3;
            pu_r <= 1'b0;
        end else begin
            wa_r <= path_setup_word_a;
            wb_r <= path_setup_word_b;
            pu_r <= power_up_bit;
            if (word_load && word_sel_b)
                held_b_r <= word_data;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    pend_set_a: assert property (word_load && word_sel_b |=> commit_pending)
        else $error("no pending commit after word b load");
    hold_words_a: assert property (!($rose(ss_n) && commit_pending) |=>
        $stable(path_setup_word_a) && $stable(path_setup_word_b))
        else $error("active words changed without commit");
    commit_b_a: assert property ($rose(ss_n) && commit_pending |=>
        !commit_pending && path_setup_word_b == $past(held_b_r))
        else $error("word b not committed on select rise");
    mix_dec_a: assert property (pu_r |-> first_summer_mix == wb_r[8:7] &&
        second_summer_mix == wb_r[6:5])
        else $error("summer mix decode wrong");
    rate_dec_a: assert property (pu_r |-> rate_sel == wb_r[3:2] &&
        filter_power_down == wb_r[1])
        else $error("rate or filter power decode wrong");
    vol_dec_a: assert property (pu_r |-> atten_db == {wb_r[13:11], 2'b00}
        && volume_source_sel == wb_r[15:14])
        else $error("volume decode wrong");
    spk_dec_a: assert property (pu_r |-> volume_power_down == wa_r[0] &&
        spk_high_gain == (wa_r[2:1] == 2'b01))
        else $error("speaker or volume power decode wrong");
    off_dec_a: assert property (!pu_r |-> filter_power_down &&
        mic_gain_power_down && volume_power_down && aux_out_power_down)
        else $error("stage powered while block is down");
endmodule
bind apc_top apc_monitor u_mon (.clk, .rst_n, .word_load, .word_sel_b,
    .word_data, .ss_n, .power_up_bit, .first_summer_mix, .second_summer_mix,
    .rate_sel, .volume_source_sel, .filter_power_down, .mic_gain_power_down,
    .volume_power_down, .atten_db, .spk_high_gain, .aux_out_power_down,
    .path_setup_word_a, .path_setup_word_b, .commit_pending);
`default_nettype wire

// ### bench/testbench.sv
// Purpose: directed tests of the setup word bank through its load port
// Assumes: host model frames every command with select
// Notes: expectations come from the word fields, not the design
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
    fail_count++; $display("wrong value at %0t: %h vs %h", $time, g, e); \
    end end
module testbench;
    import apc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic power_up_bit = 1'b0;
    logic word_load, word_sel_b, ss_n, commit_pending;
    apc_word_t word_data, path_setup_word_a, path_setup_word_b, b;
    logic [1:0] first_summer_source_sel, output_sel, speaker_drive_mode;
    apc_mix_t first_summer_mix, second_summer_mix;
    apc_rate_t rate_sel;
    apc_vsrc_t volume_source_sel;
    logic [2:0] atten_code;
    logic [4:0] atten_db;
    logic filter_input_sel, filter_power_down, mic_gain_power_down;
    logic input_source_sel, volume_power_down, spk_high_gain;
    logic aux_out_power_down;
    int fail_count = 0;
    int total_checks = 0;
    always #50 clk = ~clk;
    apc_host host (.clk, .word_load, .word_sel_b, .word_data, .ss_n);
    apc_top DUT (.clk, .rst_n, .word_load, .word_sel_b, .word_data, .ss_n,
        .power_up_bit, .first_summer_source_sel, .first_summer_mix,
        .second_summer_mix, .filter_input_sel, .filter_power_down, .rate_sel,
        .mic_gain_power_down, .input_source_sel, .volume_source_sel,
        .volume_power_down, .atten_code, .atten_db, .output_sel,
        .speaker_drive_mode, .spk_high_gain, .aux_out_power_down,
        .path_setup_word_a, .path_setup_word_b, .commit_pending);
    task automatic end_of_test;
        if (fail_count == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input apc_word_t a, input apc_word_t w);
        `CHK(first_summer_source_sel, w[10:9])
        `CHK(first_summer_mix, w[8:7])
        `CHK(filter_input_sel, w[4])
        `CHK(filter_power_down, w[1])
        `CHK(rate_sel, w[3:2])
        `CHK(second_summer_mix, w[6:5])
        `CHK(mic_gain_power_down, w[0])
        `CHK(input_source_sel, a[9])
        `CHK(volume_source_sel, w[15:14])
        `CHK(volume_power_down, a[0])
        `CHK(atten_db, {w[13:11], 2'b00})
        `CHK(output_sel, a[4:3])
        `CHK(spk_high_gain, a[2:1] == 2'b01)
        `CHK(aux_out_power_down, ~a[2])
        `CHK(atten_code, w[13:11])
        `CHK(speaker_drive_mode, a[2:1])
    endtask
    task automatic step(input logic do_a, input logic do_b,
        input apc_word_t a, input apc_word_t w, input apc_word_t ea,
        input apc_word_t ew);
        host.frame(do_a, do_b, a, w);
        #10;
        `CHK(path_setup_word_a, ea)
        `CHK(path_setup_word_b, ew)
        `CHK(commit_pending, 1'b0)
        if (power_up_bit)
            chk(ea, ew);
        else
            chk(16'h2421, 16'h01e3);
    endtask
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        power_up_bit <= 1'b1;
        @(posedge clk);
        #10;
        `CHK(path_setup_word_a, 16'h2421)
        `CHK(path_setup_word_b, 16'h01e3)
        chk(16'h2421, 16'h01e3);
        step(1, 1, 16'h440b, 16'h01e3, 16'h440b, 16'h01e3);
        step(0, 1, 16'h0000, 16'h00c5, 16'h440b, 16'h00c5);
        step(1, 1, 16'h2421, 16'h0148, 16'h2421, 16'h0148);
        step(1, 1, 16'h2422, 16'h59d1, 16'h2422, 16'h59d1);
        step(1, 0, 16'h1234, 16'h0000, 16'h2422, 16'h59d1);
        step(0, 1, 16'h0000, 16'h59d1, 16'h1234, 16'h59d1);
        for (int i = 0; i < 8; i++) begin
            b = 16'h01d1 | (16'(i) << 11) | (16'(i & 3) << 2) |
                (16'(i & 3) << 9) | (16'(i >> 1) << 14);
            step(0, 1, 16'h0000, b, 16'h1234, b);
        end
        @(posedge clk);
        power_up_bit <= 1'b0;
        step(1, 1, 16'h2422, 16'h59d1, 16'h2422, 16'h59d1);
        @(posedge clk);
        power_up_bit <= 1'b1;
        repeat (3) @(posedge clk);
        #10;
        chk(16'h2422, 16'h59d1);
        // reset in mid-run must drop a parked word a
        step(1, 0, 16'h440b, 16'h0000, 16'h2422, 16'h59d1);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #10;
        `CHK(path_setup_word_a, 16'h2421)
        `CHK(commit_pending, 1'b0)
        chk(16'h2421, 16'h01e3);
        step(0, 1, 16'h0000, 16'h00c5, 16'h2421, 16'h00c5);
        end_of_test;
    end
    // far beyond the roughly 141 cycles the tests need
    initial begin
        #300000;
        fail_count++;
        end_of_test;
    end
endmodule
`default_nettype wire

// ### include/apc_dec_if.sv
// Purpose: carries active words and decoded controls between modules
// Assumes: one clock domain
// Notes: src drives words, dec drives decoded controls
`timescale 1ns/1ps
`default_nettype none
interface apc_dec_if;
    import apc_pkg::*;
    apc_word_t word_a;
    apc_word_t word_b;
    logic [1:0] first_summer_source_sel;
    apc_mix_t first_summer_mix;
    apc_mix_t second_summer_mix;
    logic filter_input_sel;
    logic filter_power_down;
    apc_rate_t rate_sel;
    logic mic_gain_power_down;
    logic input_source_sel;
    apc_vsrc_t volume_source_sel;
    logic volume_power_down;
    logic [2:0] atten_code;
    logic [4:0] atten_db;
    logic [1:0] output_sel;
    logic [1:0] speaker_drive_mode;
    logic spk_high_gain;
    logic aux_out_power_down;
    modport src (
        output word_a, word_b,
        input first_summer_source_sel, first_summer_mix, second_summer_mix,
        input filter_input_sel, filter_power_down, rate_sel,
        input mic_gain_power_down, input_source_sel, volume_source_sel,
        input volume_power_down, atten_code, atten_db, output_sel,
        input speaker_drive_mode, spk_high_gain, aux_out_power_down
    );
    modport dec (
        input word_a, word_b,
        output first_summer_source_sel, first_summer_mix, second_summer_mix,
        output filter_input_sel, filter_power_down, rate_sel,
        output mic_gain_power_down, input_source_sel, volume_source_sel,
        output volume_power_down, atten_code, atten_db, output_sel,
        output speaker_drive_mode, spk_high_gain, aux_out_power_down
    );
endinterface
`default_nettype wire

// ### include/apc_defs.svh
// Purpose: bit positions and reset values of the audio path setup words
// Assumes: sixteen-bit words, bit 0 is the least significant
// Notes: definitions only
`ifndef APC_DEFS_SVH
`define APC_DEFS_SVH

`define APC_WORD_W 16
// word a fields
`define APC_A_VOL_PD 0
`define APC_A_SPK_LO 1
`define APC_A_SPK_HI 2
`define APC_A_OUT_LO 3
`define APC_A_OUT_HI 4
`define APC_A_INS 9
// word b fields
`define APC_B_MIC_PD 0
`define APC_B_FLT_PD 1
`define APC_B_RATE_LO 2
`define APC_B_RATE_HI 3
`define APC_B_FLT_SEL 4
`define APC_B_S2M_LO 5
`define APC_B_S2M_HI 6
`define APC_B_S1M_LO 7
`define APC_B_S1M_HI 8
`define APC_B_S1S_LO 9
`define APC_B_S1S_HI 10
`define APC_B_VOL_LO 11
`define APC_B_VOL_HI 13
`define APC_B_VLS_LO 14
`define APC_B_VLS_HI 15
// reset and powered-down words: every stage powered down
`define APC_WORD_A_OFF 16'h2421
`define APC_WORD_B_OFF 16'h01e3
// attenuation step per code
`define APC_ATTEN_STEP_DB 5'h04

`endif

// ### include/apc_pkg.sv
// Purpose: types of the audio path setup decoder
// Assumes: constants live in apc_defs.svh
// Notes: encodings follow the setup word fields
package apc_pkg;
    typedef logic [15:0] apc_word_t;
    typedef enum logic [1:0] {
        APC_RATE_8K0 = 2'h0,
        APC_RATE_6K4 = 2'h1,
        APC_RATE_5K3 = 2'h2,
        APC_RATE_4K0 = 2'h3
    } apc_rate_t;
    typedef enum logic [1:0] {
        APC_MIX_BOTH = 2'h0,
        APC_MIX_A_ONLY = 2'h1,
        APC_MIX_B_ONLY = 2'h2,
        APC_MIX_OFF = 2'h3
    } apc_mix_t;
    typedef enum logic [1:0] {
        APC_VSRC_LINE_IN = 2'h0,
        APC_VSRC_SECOND_SUMMING_STAGE = 2'h1,
        APC_VSRC_FIRST_SUMMING_STAGE = 2'h2,
        APC_VSRC_INPUT_MUX = 2'h3
    } apc_vsrc_t;
endpackage

// ### rtl/apc_decode.sv
// Purpose: registered field decode of the two active setup words
// Assumes: words already gated by the power-up state
// Notes: one cycle from word change to decoded control
`timescale 1ns/1ps
`include "apc_defs.svh"
`default_nettype none
module apc_decode (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // words in, controls out
    apc_dec_if.dec dif
);
    import apc_pkg::*;

    typedef struct packed {
        logic [1:0] s1src;
        apc_mix_t s1mix;
        apc_mix_t s2mix;
        logic fsel;
        logic fpd;
        apc_rate_t rate;
        logic micpd;
        logic ins;
        apc_vsrc_t vsrc;
        logic vpd;
        logic [2:0] att;
        logic [4:0] attdb;
        logic [1:0] osel;
        logic [1:0] spk;
        logic hg;
        logic auxpd;
    } apc_dec_t;

    apc_dec_t dec_r;
    apc_dec_t dec_nxt;

    function automatic logic [1:0] pair(input apc_word_t w, input int lo);
        pair = {w[lo + 1], w[lo]};
    endfunction

    function automatic logic [4:0] atten_of(input logic [2:0] code);
        atten_of = 5'(code * `APC_ATTEN_STEP_DB);
    endfunction

    always_comb begin
        dec_nxt.s1src = pair(dif.word_b, `APC_B_S1S_LO);
        dec_nxt.s1mix = apc_mix_t'(pair(dif.word_b, `APC_B_S1M_LO));
        dec_nxt.s2mix = apc_mix_t'(pair(dif.word_b, `APC_B_S2M_LO));
        dec_nxt.fsel = dif.word_b[`APC_B_FLT_SEL];
        dec_nxt.fpd = dif.word_b[`APC_B_FLT_PD];
        // all four codes used, 11 is the slowest rate
        dec_nxt.rate = apc_rate_t'(pair(dif.word_b, `APC_B_RATE_LO));
        dec_nxt.micpd = dif.word_b[`APC_B_MIC_PD];
        dec_nxt.ins = dif.word_a[`APC_A_INS];
        dec_nxt.vsrc = apc_vsrc_t'(pair(dif.word_b, `APC_B_VLS_LO));
        dec_nxt.vpd = dif.word_a[`APC_A_VOL_PD];
        dec_nxt.att = dif.word_b[`APC_B_VOL_HI:`APC_B_VOL_LO];
        dec_nxt.attdb = atten_of(dif.word_b[`APC_B_VOL_HI:`APC_B_VOL_LO]);
        dec_nxt.osel = pair(dif.word_a, `APC_A_OUT_LO);
        dec_nxt.spk = pair(dif.word_a, `APC_A_SPK_LO);
        dec_nxt.hg = (pair(dif.word_a, `APC_A_SPK_LO) == 2'h1);
        dec_nxt.auxpd = dif.word_a[`APC_A_SPK_HI] == 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_r <= '0;
            dec_r.s1mix <= APC_MIX_OFF;
            dec_r.s2mix <= APC_MIX_OFF;
            dec_r.fpd <= 1'b1;
            dec_r.micpd <= 1'b1;
            dec_r.vpd <= 1'b1;
            dec_r.auxpd <= 1'b1;
        end else begin
            dec_r <= dec_nxt;
        end
    end

    assign dif.first_summer_source_sel = dec_r.s1src;
    assign dif.first_summer_mix = dec_r.s1mix;
    assign dif.second_summer_mix = dec_r.s2mix;
    assign dif.filter_input_sel = dec_r.fsel;
    assign dif.filter_power_down = dec_r.fpd;
    assign dif.rate_sel = dec_r.rate;
    assign dif.mic_gain_power_down = dec_r.micpd;
    assign dif.input_source_sel = dec_r.ins;
    assign dif.volume_source_sel = dec_r.vsrc;
    assign dif.volume_power_down = dec_r.vpd;
    assign dif.atten_code = dec_r.att;
    assign dif.atten_db = dec_r.attdb;
    assign dif.output_sel = dec_r.osel;
    assign dif.speaker_drive_mode = dec_r.spk;
    assign dif.spk_high_gain = dec_r.hg;
    assign dif.aux_out_power_down = dec_r.auxpd;
endmodule
`default_nettype wire

// ### rtl/apc_top.sv
// Purpose: audio path setup word bank with staged commit and decode
// Assumes: load strobes come from the serial command decoder
// Notes: commit happens on the slave select rising edge
//
// Function
// - word b bits 10..9 pick first summer source, 00 is line input.
// - word b bit7=1, bit8=0 makes first summer pass its source mux only.
// - word b bit7=0, bit8=1 makes first summer pass input mux only.
// - word b bit4 picks filter input: first summer or array playback.
// - word b bit1 powers filter down; zero powers it up.
// - word b bits 3..2 give 8.0, 6.4, 5.3, 4.0 kHz rates.
// - word b bit5=0, bit6=1 makes second summer pass filter only.
// - array record input is always the second summer output.
// - word b bit0 powers microphone gain amplifier down.
// - word a bit9 picks input source; zero is microphone amplifier.
// - word b bit14=1, bit15=0 picks second summer for volume stage.
// - word a bit0 powers the volume stage down.
// - word b bits 13..11 are attenuation code, 4 dB per step.
// - word a bits 4..3 both zero route volume stage to speaker.
// - word a bit1=1, bit2=0 gives high gain speaker, aux off.
// - loading word a only fills a holding register.
// - word b load commits b and held a at slave select rise.
// - loads accepted while powered down; outputs follow once powered up.
`timescale 1ns/1ps
`include "apc_defs.svh"
`default_nettype none
module apc_top (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // word load from the serial command decoder
    input wire logic word_load,
    input wire logic word_sel_b,
    input wire apc_pkg::apc_word_t word_data,
    input wire logic ss_n,
    // power state
    input wire logic power_up_bit,
    // decoded controls
    output logic [1:0] first_summer_source_sel,
    output apc_pkg::apc_mix_t first_summer_mix,
    output apc_pkg::apc_mix_t second_summer_mix,
    output logic filter_input_sel,
    output logic filter_power_down,
    output apc_pkg::apc_rate_t rate_sel,
    output logic mic_gain_power_down,
    output logic input_source_sel,
    output apc_pkg::apc_vsrc_t volume_source_sel,
    output logic volume_power_down,
    output logic [2:0] atten_code,
    output logic [4:0] atten_db,
    output logic [1:0] output_sel,
    output logic [1:0] speaker_drive_mode,
    output logic spk_high_gain,
    output logic aux_out_power_down,
    // status
    output apc_pkg::apc_word_t path_setup_word_a,
    output apc_pkg::apc_word_t path_setup_word_b,
    output logic commit_pending
);
    import apc_pkg::*;

    apc_word_t hold_a_r, hold_a_nxt;
    logic hold_a_vld_r, hold_a_vld_nxt;
    apc_word_t stage_b_r, stage_b_nxt;
    logic pend_r, pend_nxt;
    apc_word_t act_a_r, act_a_nxt;
    apc_word_t act_b_r, act_b_nxt;
    logic ss_n_r;
    logic ss_rise;

    apc_dec_if dif ();

    assign ss_rise = ss_n && !ss_n_r;

    always_comb begin
        hold_a_nxt = hold_a_r;
        hold_a_vld_nxt = hold_a_vld_r;
        stage_b_nxt = stage_b_r;
        pend_nxt = pend_r;
        act_a_nxt = act_a_r;
        act_b_nxt = act_b_r;
        // loads land even while powered down
        if (word_load && !word_sel_b) begin
            hold_a_nxt = word_data;
            hold_a_vld_nxt = 1'b1;
        end
        if (word_load && word_sel_b) begin
            stage_b_nxt = word_data;
            pend_nxt = 1'b1;
        end
        // a held word a without a later b stays parked, as intended
        if (ss_rise && pend_r) begin
            act_b_nxt = stage_b_r;
            if (hold_a_vld_r) begin
                act_a_nxt = hold_a_r;
            end
            // a b load in the commit cycle waits for the next rise
            pend_nxt = word_load && word_sel_b;
            hold_a_vld_nxt = word_load && !word_sel_b;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hold_a_r <= `APC_WORD_A_OFF;
            hold_a_vld_r <= 1'b0;
            stage_b_r <= `APC_WORD_B_OFF;
            pend_r <= 1'b0;
            act_a_r <= `APC_WORD_A_OFF;
            act_b_r <= `APC_WORD_B_OFF;
            ss_n_r <= 1'b1;
        end else begin
            hold_a_r <= hold_a_nxt;
            hold_a_vld_r <= hold_a_vld_nxt;
            stage_b_r <= stage_b_nxt;
            pend_r <= pend_nxt;
            act_a_r <= act_a_nxt;
            act_b_r <= act_b_nxt;
            ss_n_r <= ss_n;
        end
    end

    // powered down: decoder sees the all-off words
    assign dif.word_a = power_up_bit ? act_a_r : `APC_WORD_A_OFF;
    assign dif.word_b = power_up_bit ? act_b_r : `APC_WORD_B_OFF;

    // no record source select exists: array input is hard wired to second_summing_stage
    apc_decode u_decode (
        .clk(clk),
        .rst_n(rst_n),
        .dif(dif)
    );

    assign first_summer_source_sel = dif.first_summer_source_sel;
    assign first_summer_mix = dif.first_summer_mix;
    assign second_summer_mix = dif.second_summer_mix;
    assign filter_input_sel = dif.filter_input_sel;
    assign filter_power_down = dif.filter_power_down;
    assign rate_sel = dif.rate_sel;
    assign mic_gain_power_down = dif.mic_gain_power_down;
    assign input_source_sel = dif.input_source_sel;
    assign volume_source_sel = dif.volume_source_sel;
    assign volume_power_down = dif.volume_power_down;
    assign atten_code = dif.atten_code;
    assign atten_db = dif.atten_db;
    assign output_sel = dif.output_sel;
    assign speaker_drive_mode = dif.speaker_drive_mode;
    assign spk_high_gain = dif.spk_high_gain;
    assign aux_out_power_down = dif.aux_out_power_down;
    assign path_setup_word_a = act_a_r;
    assign path_setup_word_b = act_b_r;
    assign commit_pending = pend_r;
endmodule
`default_nettype wire
